// ### inc/pio_channel_consts.vh
`ifndef PIO_CHANNEL_CONSTS_VH
`define PIO_CHANNEL_CONSTS_VH

// address bit 0 selects data (0) or control/status (1)
`define ADDR_DATA 1'b0
`define ADDR_CTRL 1'b1

// command word fields
`define CMD_OUT_EN 0
`define CMD_INT_EN 1
`define CMD_IN_EN 2
`define CMD_DEV_CTRL 5
`define CMD_SOFT_RESET 6
`define CMD_RESET_VALUE 8'h00

// status byte fields
`define STAT_OUT_READY 0
`define STAT_IN_AVAIL 1
`define STAT_DEV_READY_LOW 7

// mode word the host is expected to write (octal 116)
`define MODE_WORD_VALUE 8'h4E

// handshake strobe timebase: system clock divided by 5 then by 4
`define STROBE_DIV 5'd20
`define STROBE_DIV_LAST 5'd19
`define DIV_WIDTH 5

// edges after reset release before the strap synchroniser holds the pin level
`define STRAP_SETTLE 2'b10

// output buffer shape
`define OBUF_WIDTH 8
`define OBUF_DEPTH 4
`define OBUF_AW 2

`endif

// ### logic/byte_fifo.v
`timescale 1ns/1ps
`default_nettype none

module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clk,
    input wire rst_n,
    input wire flush,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_ff;
    reg [AW-1:0] rd_ptr_ff;
    reg [AW:0] count_ff;
    wire push;
    wire pop;
    integer i;

    assign in_ready = (count_ff != DEPTH[AW:0]);
    assign out_valid = (count_ff != {(AW+1){1'b0}});
    assign out_data = mem_ff[rd_ptr_ff];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff <= {(AW+1){1'b0}};
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_ff[i] <= {WIDTH{1'b0}};
            end
        end else if (flush) begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                mem_ff[wr_ptr_ff] <= in_data;
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// ### logic/pio_channel.v
// Operation
// R01 - even address is data port, odd address is control and status
// R02 - data port write puts the byte on the output data lines
// R03 - data port read returns the byte from the input data lines
// R04 - host initialises with a mode word then a command word
// R05 - host always writes octal 116 as the mode word
// R06 - once mode is taken, ignore mode until hard or soft reset
// R07 - later control writes are command words, rewritable any time
// R08 - command bit 0 output enable, bit 1 interrupt, bit 2 input enable
// R09 - command bit 5 set drives both control lines low, clear drives high
// R10 - command bit 6 set resets channel back to awaiting mode word
// R11 - host writes zero in command bits 3 and 4
// R12 - control address read returns status byte
// R13 - status bit 0 set when a new output byte can be accepted
// R14 - status bit 1 set when an input byte awaits collection
// R15 - status bit 7 set while peripheral ready line is low
// R16 - output data true or inverted by static strap
// R17 - output bits ascend from pin one, input pins descend to the LSB
// R18 - host order: reset, mode, command, status, then data
// R19 - handshake actions trigger on high-to-low transitions
// R20 - newly latched output byte gives one strobe on the divided clock
// R21 - falling acknowledge clears output full, output ready returns
// R22 - host checks output ready before writing a new byte
// R23 - channel drives strobe, request, control; peripheral drives the rest
// R24 - falling input strobe latches input, sets available; data read clears
`timescale 1ns/1ps
`default_nettype none
`include "pio_channel_consts.vh"

module pio_channel (
    input wire CLK,
    input wire RST_N,
    input wire SEL,
    input wire ADDR0,
    input wire IO_WR,
    input wire IO_RD,
    input wire [7:0] WDATA,
    output reg [7:0] RDATA,
    output reg [7:0] OUT_DATA,
    output reg TAKE_DATA_N,
    input wire DATA_TAKEN,
    input wire [7:0] IN_PINS,
    input wire DATA_SENT,
    output reg SEND_DATA_N,
    input wire DEVICE_READY,
    output reg DEV_CTRL_A,
    output reg DEV_CTRL_B,
    output reg INT_ENABLE,
    input wire POLARITY_INVERT_STRAP
);

    // pin synchronisers: first stage read only by the second
    reg [7:0] in_s1_ff;
    reg [7:0] in_s2_ff;
    reg sent_s1_ff;
    reg sent_s2_ff;
    reg sent_d_ff;
    reg taken_s1_ff;
    reg taken_s2_ff;
    reg taken_d_ff;
    reg rdy_s1_ff;
    reg rdy_s2_ff;
    reg strap_s1_ff;
    reg strap_s2_ff;

    // channel state
    reg mode_set_ff;
    reg [7:0] cmd_ff;
    reg invert_ff;
    reg strap_taken_ff;
    reg [1:0] strap_wait_ff;
    reg [7:0] out_reg_ff;
    reg output_full_ff;
    reg strobe_pend_ff;
    reg [7:0] in_buf_ff;
    reg in_avail_ff;
    reg [`DIV_WIDTH-1:0] div_ff;

    wire data_wr;
    wire data_rd;
    wire ctrl_wr;
    wire ctrl_rd;
    wire soft_reset;
    wire tick;
    wire sent_fall;
    wire output_full_clear;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire fifo_out_ready;
    wire [7:0] fifo_out_data;
    reg [7:0] in_byte;
    reg [7:0] status;
    integer k;

    assign data_wr = SEL & IO_WR & (ADDR0 == `ADDR_DATA); // R01
    assign data_rd = SEL & IO_RD & (ADDR0 == `ADDR_DATA); // R01
    assign ctrl_wr = SEL & IO_WR & (ADDR0 == `ADDR_CTRL); // R01
    assign ctrl_rd = SEL & IO_RD & (ADDR0 == `ADDR_CTRL); // R01
    assign soft_reset = ctrl_wr & mode_set_ff & WDATA[`CMD_SOFT_RESET]; // R10
    assign tick = (div_ff == `STROBE_DIV_LAST);
    assign sent_fall = sent_d_ff & ~sent_s2_ff; // R19
    assign output_full_clear = taken_d_ff & ~taken_s2_ff; // R19 R21

    // the buffer feeds the output latch only while output is enabled
    assign fifo_out_ready = mode_set_ff & cmd_ff[`CMD_OUT_EN] & ~output_full_ff;

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            in_s1_ff <= 8'h00;
            in_s2_ff <= 8'h00;
            sent_s1_ff <= 1'b1;
            sent_s2_ff <= 1'b1;
            sent_d_ff <= 1'b1;
            taken_s1_ff <= 1'b1;
            taken_s2_ff <= 1'b1;
            taken_d_ff <= 1'b1;
            rdy_s1_ff <= 1'b1;
            rdy_s2_ff <= 1'b1;
            strap_s1_ff <= 1'b0;
            strap_s2_ff <= 1'b0;
        end else begin
            in_s1_ff <= IN_PINS;
            in_s2_ff <= in_s1_ff;
            sent_s1_ff <= DATA_SENT;
            sent_s2_ff <= sent_s1_ff;
            sent_d_ff <= sent_s2_ff;
            taken_s1_ff <= DATA_TAKEN;
            taken_s2_ff <= taken_s1_ff;
            taken_d_ff <= taken_s2_ff;
            rdy_s1_ff <= DEVICE_READY;
            rdy_s2_ff <= rdy_s1_ff;
            strap_s1_ff <= POLARITY_INVERT_STRAP;
            strap_s2_ff <= strap_s1_ff;
        end
    end

    // input pins run from D7 at the first pin down to D0 at the last
    always @* begin
        in_byte = 8'h00;
        for (k = 0; k < 8; k = k + 1) begin
            in_byte[k] = in_s2_ff[7-k]; // R17
        end
    end

    // strap is static: caught once, after the synchroniser has refilled from reset
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            strap_wait_ff <= 2'b00;
            strap_taken_ff <= 1'b0;
            invert_ff <= 1'b0;
        end else if (!strap_taken_ff) begin
            if (strap_wait_ff == `STRAP_SETTLE) begin
                strap_taken_ff <= 1'b1;
                invert_ff <= strap_s2_ff; // R16
            end else begin
                strap_wait_ff <= strap_wait_ff + 2'b01;
            end
        end
    end

    // mode and command words
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode_set_ff <= 1'b0;
            cmd_ff <= `CMD_RESET_VALUE;
        end else if (ctrl_wr) begin
            if (!mode_set_ff) begin
                // any value is taken as the mode word; only one is meaningful
                mode_set_ff <= 1'b1; // R04 R06
            end else if (soft_reset) begin
                mode_set_ff <= 1'b0; // R10
                cmd_ff <= `CMD_RESET_VALUE; // R10
            end else begin
                cmd_ff <= WDATA; // R07 R08
            end
        end
    end

    // divided timebase for the output strobe
    // free running, so the first strobe waits up to one divided period
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            div_ff <= {`DIV_WIDTH{1'b0}};
        end else if (tick) begin
            div_ff <= {`DIV_WIDTH{1'b0}};
        end else begin
            div_ff <= div_ff + 1'b1;
        end
    end

    // output latch and handshake
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            out_reg_ff <= 8'h00;
            output_full_ff <= 1'b0;
            strobe_pend_ff <= 1'b0;
            TAKE_DATA_N <= 1'b1;
        end else if (soft_reset) begin
            output_full_ff <= 1'b0;
            strobe_pend_ff <= 1'b0;
            TAKE_DATA_N <= 1'b1;
        end else begin
            // a load beats a stale acknowledge in the same cycle
            if (fifo_out_valid && fifo_out_ready) begin
                out_reg_ff <= fifo_out_data; // R02
                output_full_ff <= 1'b1;
                strobe_pend_ff <= 1'b1; // R20
            end else if (output_full_clear) begin
                output_full_ff <= 1'b0; // R21
            end
            // strobe goes low for one divided period, aligned to the tick
            if (tick) begin
                if (!TAKE_DATA_N) begin
                    TAKE_DATA_N <= 1'b1;
                end else if (strobe_pend_ff) begin
                    TAKE_DATA_N <= 1'b0; // R19 R20 R23
                    strobe_pend_ff <= 1'b0;
                end
            end
        end
    end

    // output lines follow the latch, true or inverted
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            OUT_DATA <= 8'h00;
        end else begin
            OUT_DATA <= out_reg_ff ^ {8{invert_ff}}; // R16 R17
        end
    end

    // input capture; a new byte in the read cycle keeps the flag set
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            in_buf_ff <= 8'h00;
            in_avail_ff <= 1'b0;
        end else if (soft_reset) begin
            in_avail_ff <= 1'b0;
        end else if (sent_fall && mode_set_ff && cmd_ff[`CMD_IN_EN]) begin
            in_buf_ff <= in_byte; // R24
            in_avail_ff <= 1'b1; // R24
        end else if (data_rd) begin
            in_avail_ff <= 1'b0; // R24
        end
    end

    // status byte, reserved bits read zero
    always @* begin
        status = 8'h00;
        status[`STAT_OUT_READY] = fifo_in_ready; // R13 R22
        status[`STAT_IN_AVAIL] = in_avail_ff; // R14
        status[`STAT_DEV_READY_LOW] = ~rdy_s2_ff; // R15
    end

    // read data registered one cycle after the read strobe
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= 8'h00;
        end else if (data_rd) begin
            RDATA <= in_buf_ff; // R03
        end else if (ctrl_rd) begin
            RDATA <= status; // R12
        end
    end

    // peripheral control lines and request
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            DEV_CTRL_A <= 1'b1;
            DEV_CTRL_B <= 1'b1;
            SEND_DATA_N <= 1'b1;
            INT_ENABLE <= 1'b0;
        end else begin
            DEV_CTRL_A <= ~cmd_ff[`CMD_DEV_CTRL]; // R09 R23
            DEV_CTRL_B <= ~cmd_ff[`CMD_DEV_CTRL]; // R09 R23
            // request falls when input is enabled and the buffer is empty
            SEND_DATA_N <= ~(mode_set_ff & cmd_ff[`CMD_IN_EN] & ~in_avail_ff); // R19 R23
            INT_ENABLE <= cmd_ff[`CMD_INT_EN]; // R08
        end
    end

    // write buffer: status bit 0 clears when it fills; further host writes are dropped
    byte_fifo #(
        .WIDTH(`OBUF_WIDTH),
        .DEPTH(`OBUF_DEPTH),
        .AW(`OBUF_AW)
    ) u_obuf (
        .clk(CLK),
        .rst_n(RST_N),
        .flush(soft_reset),
        .in_valid(data_wr), // R02
        .in_ready(fifo_in_ready),
        .in_data(WDATA),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

endmodule

`default_nettype wire

// ### dv/pio_channel_props.sv
`timescale 1ns/1ps
`default_nettype none
module pio_channel_props (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic SEL,
    input wire logic ADDR0,
    input wire logic IO_WR,
    input wire logic IO_RD,
    input wire logic [7:0] WDATA,
    input wire logic [7:0] RDATA,
    input wire logic [7:0] OUT_DATA,
    input wire logic TAKE_DATA_N,
    input wire logic SEND_DATA_N,
    input wire logic DEV_CTRL_A,
    input wire logic DEV_CTRL_B,
    input wire logic INT_ENABLE
);
    logic mode_ff;
    logic [4:0] low_cnt_ff;
    wire ctrl_wr = SEL && IO_WR && ADDR0;
    // shadow of the mode flag, so command writes can be told from mode writes
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode_ff <= 1'b0;
            low_cnt_ff <= 5'h00;
        end else begin
            if (ctrl_wr)
                mode_ff <= !mode_ff || !WDATA[6];
            low_cnt_ff <= TAKE_DATA_N ? 5'h00 : low_cnt_ff + 5'h01;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    property p_ctrl_pair; DEV_CTRL_A == DEV_CTRL_B; endproperty
    a_ctrl_pair: assert property (p_ctrl_pair) else $error("control lines differ");
    property p_cmd_apply;
        ctrl_wr && mode_ff && !WDATA[6]
        |-> ##2 DEV_CTRL_A == !$past(WDATA[5], 2) && INT_ENABLE == $past(WDATA[1], 2);
    endproperty
    a_cmd_apply: assert property (p_cmd_apply) else $error("command not applied");
    property p_soft_reset;
        ctrl_wr && mode_ff && WDATA[6] |-> ##2 DEV_CTRL_A && !INT_ENABLE;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset missed");
    property p_mode_first;
        ctrl_wr && !mode_ff |-> ##2 $stable(INT_ENABLE) && $stable(DEV_CTRL_A);
    endproperty
    a_mode_first: assert property (p_mode_first) else $error("mode taken as command");
    property p_strobe_len; $rose(TAKE_DATA_N) |-> low_cnt_ff == 5'd20; endproperty
    a_strobe_len: assert property (p_strobe_len) else $error("strobe length");
    property p_strobe_max; !TAKE_DATA_N |-> low_cnt_ff < 5'd20; endproperty
    a_strobe_max: assert property (p_strobe_max) else $error("strobe too long");
    property p_status_zero; SEL && IO_RD && ADDR0 |=> RDATA[6:2] == 5'h00; endproperty
    a_status_zero: assert property (p_status_zero) else $error("status spare bits");
    property p_rdata_hold; !(SEL && IO_RD) |=> $stable(RDATA); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_out_hold; !TAKE_DATA_N && $stable(TAKE_DATA_N) |-> $stable(OUT_DATA); endproperty
    a_out_hold: assert property (p_out_hold) else $error("output moved in strobe");
    property p_in_disable;
        ctrl_wr && mode_ff && !WDATA[6] && !WDATA[2] |-> ##[1:3] SEND_DATA_N;
    endproperty
    a_in_disable: assert property (p_in_disable) else $error("request while disabled");
endmodule
`default_nettype wire

// ### dv/periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module periph_model (
    input wire logic clk,
    input wire logic take_data_n,
    input wire logic send_data_n,
    input wire logic [7:0] out_data,
    input wire logic slow,
    output logic data_taken,
    output logic data_sent,
    output logic [7:0] in_pins
);
    logic [7:0] got[$];
    initial begin
        data_taken = 1'b1;
        data_sent = 1'b1;
        in_pins = 8'hA5;
    end
    // ack only after the strobe ends, so the next byte never lands mid-strobe
    always begin
        @(negedge take_data_n);
        #1 got.push_back(out_data);
        @(posedge take_data_n);
        repeat (slow ? 40 : 1) @(posedge clk);
        data_taken <= 1'b0;
        repeat (4) @(posedge clk);
        data_taken <= 1'b1;
    end
    task send(input logic [7:0] b, input logic force_it);
        integer n;
        n = 0;
        while (send_data_n !== 1'b0 && !force_it && n < 200) begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        in_pins <= {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
        repeat (4) @(posedge clk);
        data_sent <= 1'b0;
        repeat (5) @(posedge clk);
        data_sent <= 1'b1;
        in_pins <= ~{b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
    endtask
endmodule
`default_nettype wire

// ### dv/handshaked_parallel_io_channel_tb.sv
`timescale 1ns/1ps
`default_nettype none
module handshaked_parallel_io_channel_tb;
    logic CLK, RST_N, SEL, ADDR0, IO_WR, IO_RD, DATA_TAKEN, DATA_SENT, DEVICE_READY, slow;
    logic POLARITY_INVERT_STRAP, TAKE_DATA_N, SEND_DATA_N, DEV_CTRL_A, DEV_CTRL_B, INT_ENABLE;
    logic [7:0] WDATA, RDATA, OUT_DATA, IN_PINS, v, b;
    logic [7:0] sent[$];
    logic [7:0] cmds [0:3] = '{8'h05, 8'h27, 8'h22, 8'h04};
    integer miscompares = 0, checks = 0, cyc = 0, i, s;
    pio_channel i_dut (.CLK(CLK), .RST_N(RST_N), .SEL(SEL), .ADDR0(ADDR0), .IO_WR(IO_WR),
        .IO_RD(IO_RD), .WDATA(WDATA), .RDATA(RDATA), .OUT_DATA(OUT_DATA),
        .TAKE_DATA_N(TAKE_DATA_N), .DATA_TAKEN(DATA_TAKEN), .IN_PINS(IN_PINS),
        .DATA_SENT(DATA_SENT), .SEND_DATA_N(SEND_DATA_N), .DEVICE_READY(DEVICE_READY),
        .DEV_CTRL_A(DEV_CTRL_A), .DEV_CTRL_B(DEV_CTRL_B), .INT_ENABLE(INT_ENABLE),
        .POLARITY_INVERT_STRAP(POLARITY_INVERT_STRAP));
    periph_model i_per (.clk(CLK), .take_data_n(TAKE_DATA_N), .send_data_n(SEND_DATA_N),
        .out_data(OUT_DATA), .slow(slow), .data_taken(DATA_TAKEN), .data_sent(DATA_SENT),
        .in_pins(IN_PINS));
    function logic [7:0] stat(input logic dev_rdy, input logic avail, input logic notfull);
        return {~dev_rdy, 5'h00, avail, notfull};
    endfunction
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task print_verdict;
        if (miscompares == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task wr(input logic a, input logic [7:0] d);
        @(posedge CLK);
        SEL <= 1'b1;
        ADDR0 <= a;
        IO_WR <= 1'b1;
        WDATA <= d;
        @(posedge CLK);
        SEL <= 1'b0;
        IO_WR <= 1'b0;
    endtask
    task rd(input logic a, output logic [7:0] d);
        @(posedge CLK);
        SEL <= 1'b1;
        ADDR0 <= a;
        IO_RD <= 1'b1;
        @(posedge CLK);
        SEL <= 1'b0;
        IO_RD <= 1'b0;
        @(posedge CLK);
        #1 d = RDATA;
    endtask
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    // the whole run needs well under this many cycles
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            miscompares++;
            print_verdict;
        end
    end
    initial begin
        {RST_N, SEL, ADDR0, IO_WR, IO_RD, slow, POLARITY_INVERT_STRAP} = 7'h00;
        WDATA = 8'h00;
        DEVICE_READY = 1'b1;
        void'($urandom(32'h84da));
        for (s = 0; s < 2; s++) begin
            @(posedge CLK);
            RST_N <= 1'b0;
            POLARITY_INVERT_STRAP <= s[0];
            repeat (8) @(posedge CLK);
            chk({TAKE_DATA_N, SEND_DATA_N, DEV_CTRL_A, DEV_CTRL_B, INT_ENABLE}, 8'h1E);
            chk(RDATA | OUT_DATA, 8'h00);
            RST_N <= 1'b1;
            wr(1'b1, 8'h4E);
            for (i = 0; i < 4; i++) begin
                wr(1'b1, cmds[i]);
                repeat (4) @(posedge CLK);
                v = cmds[i];
                chk({DEV_CTRL_A, DEV_CTRL_B, INT_ENABLE, SEND_DATA_N}, {~v[5], ~v[5], v[1], ~v[2]});
            end
            for (i = 0; i < 2; i++) begin
                DEVICE_READY <= i[0];
                repeat (5) @(posedge CLK);
                rd(1'b1, v);
                chk(v, stat(i[0], 1'b0, 1'b1));
            end
            // output disabled: four bytes fill the buffer, the fifth is dropped
            for (i = 0; i < 5; i++) begin
                b = 8'($urandom);
                if (i < 4)
                    sent.push_back(b ^ {8{s[0]}});
                wr(1'b0, b);
            end
            rd(1'b1, v);
            chk(v, stat(1'b1, 1'b0, 1'b0));
            slow <= 1'($urandom);
            wr(1'b1, 8'h05);
            i = 0;
            while (i_per.got.size() < 4 && i < 3000) begin
                @(posedge CLK);
                i++;
            end
            repeat (80) @(posedge CLK);
            chk(8'(i_per.got.size()), 8'h04);
            for (i = 0; i < 4; i++)
                chk(i_per.got[i], sent[i]);
            i_per.got.delete();
            sent.delete();
            rd(1'b1, v);
            chk(v, stat(1'b1, 1'b0, 1'b1));
            b = 8'($urandom);
            i_per.send(b, 1'b0);
            repeat (5) @(posedge CLK);
            rd(1'b1, v);
            chk(v, stat(1'b1, 1'b1, 1'b1));
            rd(1'b0, v);
            chk(v, b);
            rd(1'b1, v);
            chk(v, stat(1'b1, 1'b0, 1'b1));
            wr(1'b1, 8'h23);
            i_per.send(8'h3C, 1'b1);
            repeat (5) @(posedge CLK);
            rd(1'b1, v);
            chk(v, stat(1'b1, 1'b0, 1'b1));
            wr(1'b1, 8'h40);
            repeat (2) @(posedge CLK);
            chk({DEV_CTRL_A, INT_ENABLE}, 8'h02);
            wr(1'b1, 8'h22);
            repeat (2) @(posedge CLK);
            chk(INT_ENABLE, 8'h00);
            wr(1'b1, 8'h22);
            repeat (2) @(posedge CLK);
            chk({DEV_CTRL_A, INT_ENABLE}, 8'h01);
            // a control write without select must change nothing
            @(posedge CLK);
            ADDR0 <= 1'b1;
            IO_WR <= 1'b1;
            WDATA <= 8'h40;
            @(posedge CLK);
            IO_WR <= 1'b0;
            repeat (2) @(posedge CLK);
            chk(INT_ENABLE, 8'h01);
        end
        print_verdict;
    end
endmodule
bind pio_channel pio_channel_props i_props (.CLK(CLK), .RST_N(RST_N), .SEL(SEL),
    .ADDR0(ADDR0), .IO_WR(IO_WR), .IO_RD(IO_RD), .WDATA(WDATA), .RDATA(RDATA),
    .OUT_DATA(OUT_DATA), .TAKE_DATA_N(TAKE_DATA_N), .SEND_DATA_N(SEND_DATA_N),
    .DEV_CTRL_A(DEV_CTRL_A), .DEV_CTRL_B(DEV_CTRL_B), .INT_ENABLE(INT_ENABLE));
`default_nettype wire
